/* File: hdl/btc_pkg.sv */
// Package: register map, field positions and reset values of the test and weights config block
// What this block does
// RULE1: Test mode seven source: Barker or I/Q.
// RULE2: Bit six forces high rate operation.
// RULE3: Length counter counts bits, resets receiver.
// RULE4: Test bus tristated and used as input.
// RULE5: Spreading omitted at low rates.
// RULE6: Scrambler disabled by zeroing feedback taps.
// RULE7: Two noise generators, held initialised while disabled.
// RULE8: Software writes enable zero before one.
// RULE9: Coherent gain control disable bit.
// RULE10: Service bit detection or forced locked tracking.
// RULE11: Auto locked tracking needs both bits set.
// RULE12: DC offset compensation enabled when clear.
// RULE13: Converter bypass takes I/Q from test bus.
// RULE14: Time tracking disable overrides tracking mode.
// RULE15: Loopback bypasses converters, serial pin locks.
// RULE16: Noise output routed to test bus bits.
// RULE17: Eight bit test bus select register.
// RULE18: Energy threshold relative or absolute.
// RULE19: Energy detect when strength exceeds threshold; absolute mode compares only strength bits 6:0.
// RULE20: Default or calculated matched filter weights.
// RULE21: Force bits override weight selection.
// RULE22: Software never sets both force bits.
// RULE23: Threshold field widths four and five bits.
// RULE24: Unused bits stored, software writes zero.
package btc_pkg;
	localparam int unsigned NREG = 8;
	localparam logic [7:0] IDX_TEST_ONE = 8'h40;
	localparam logic [7:0] IDX_TEST_TWO = 8'h42;
	localparam logic [7:0] IDX_TB_SEL = 8'h44;
	localparam logic [7:0] IDX_ENERGY_THR = 8'h46;
	localparam logic [7:0] IDX_DS_THR = 8'h48;
	localparam logic [7:0] IDX_TONE_THR = 8'h4a;
	localparam logic [7:0] IDX_SNR_ONE = 8'h4c;
	localparam logic [7:0] IDX_SNR_TWO = 8'h4e;
	// Byte address is four times the printed index
	localparam logic [11:0] REG_ADR [NREG] = '{
		{2'b00, IDX_TEST_ONE, 2'b00}, {2'b00, IDX_TEST_TWO, 2'b00},
		{2'b00, IDX_TB_SEL, 2'b00}, {2'b00, IDX_ENERGY_THR, 2'b00},
		{2'b00, IDX_DS_THR, 2'b00}, {2'b00, IDX_TONE_THR, 2'b00},
		{2'b00, IDX_SNR_ONE, 2'b00}, {2'b00, IDX_SNR_TWO, 2'b00}};
	localparam int unsigned R_TM1 = 0;
	localparam int unsigned R_TM2 = 1;
	localparam int unsigned R_TBS = 2;
	localparam int unsigned R_ENERGY = 3;
	localparam int unsigned R_DS = 4;
	localparam int unsigned R_TONE = 5;
	localparam int unsigned R_SNR1 = 6;
	localparam int unsigned R_SNR2 = 7;
	localparam logic [7:0] REG_RST = 8'h00;
	// Test modes one
	localparam int unsigned TM1_DAC7 = 7;
	localparam int unsigned TM1_HIRATE = 6;
	localparam int unsigned TM1_LENCNT = 5;
	localparam int unsigned TM1_TBIN = 4;
	localparam int unsigned TM1_NOSPREAD = 3;
	localparam int unsigned TM1_NOSCR = 2;
	localparam int unsigned TM1_NOISE_FAST = 1;
	localparam int unsigned TM1_NOISE_SLOW = 0;
	// Test modes two
	localparam int unsigned TM2_NOCGC = 7;
	localparam int unsigned TM2_FORCELOCK = 6;
	localparam int unsigned TM2_NODC = 5;
	localparam int unsigned TM2_ADCBYP = 4;
	localparam int unsigned TM2_NOTRACK = 3;
	localparam int unsigned TM2_LOOP = 2;
	localparam int unsigned TM2_NOISE_LO = 1;
	localparam int unsigned TM2_NOISE_HI = 0;
	localparam int unsigned ENERGY_ABS = 7;
	localparam int unsigned TONE_FDEF = 6;
	localparam int unsigned TONE_FCALC = 5;
	localparam int unsigned SVC_LOCK_BIT = 2;
	localparam int unsigned NOISE_W = 7;
	localparam logic [6:0] NOISE_SEED = 7'h7f;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} btc_wr_e;
endpackage

/* File: hdl/btc_pn_gen.sv */
// Pseudo-noise generator, a seven bit linear feedback shift register
`timescale 1ns/100ps
module btc_noise_gen (
	input wire logic clk_i,
	input wire logic srst_i,
	btc_noise_if.gen ng
);
	always_ff @(posedge clk_i) begin
		if (srst_i || !ng.enable) begin
			ng.word <= btc_pkg::NOISE_SEED; // RULE7
		end else if (ng.step) begin
			ng.word <= {ng.word[5:0], ng.word[6] ^ ng.word[5]};
		end
	end
endmodule

/* File: hdl/btc_pn_if.sv */
// Interface: control and output of one pseudo-noise generator
`timescale 1ns/100ps
interface btc_noise_if;
	logic enable;
	logic step;
	logic [btc_pkg::NOISE_W-1:0] word;
	modport gen (input enable, input step, output word);
	modport ctl (output enable, output step, input word);
endinterface

/* File: hdl/btc_top.sv */
// Test mode and matched filter weight configuration registers with AXI4-Lite access
`timescale 1ns/100ps
module btc_top (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [7:0] test_bus_input_i,
	output logic [7:0] test_bus_o,
	output logic test_bus_oe_o,
	input wire logic [7:0] test_probe_i,
	input wire logic serial_data_in_pin_i,
	input wire logic acq_lock_i,
	input wire logic [5:0] adc_i_i,
	input wire logic [5:0] adc_q_i,
	input wire logic [5:0] loop_i_i,
	input wire logic [5:0] loop_q_i,
	input wire logic [7:0] rx_service_i,
	input wire logic config_reg_six_lock_i,
	input wire logic [7:0] rssi_i,
	input wire logic [7:0] noise_floor_i,
	input wire logic continuous_wave_tone_i,
	input wire logic [4:0] delay_spread_i,
	output logic dac_test7_iq_o,
	output logic force_high_rate_o,
	output logic length_counts_bits_o,
	output logic rx_reset_o,
	output logic spread_bypass_o,
	output logic scrambler_taps_zero_o,
	output logic coherent_gain_off_o,
	output logic dc_comp_en_o,
	output logic locked_time_track_o,
	output logic time_track_off_o,
	output logic loopback_o,
	output logic [5:0] rx_i_o,
	output logic [5:0] rx_q_o,
	output logic acq_lock_o,
	output logic [7:0] test_bus_select_o,
	output logic energy_detect_o,
	output logic use_default_weights_o
);
	logic [7:0] regs_ff [btc_pkg::NREG];
	btc_pkg::btc_wr_e wr_st_ff;
	logic aw_full_ff, w_full_ff;
	logic [11:0] aw_addr_ff;
	logic [7:0] w_data_ff;
	logic w_lane0_ff;
	logic aw_take, w_take, ar_take, commit;
	logic nxt_aw_full, nxt_w_full, nxt_rvalid;
	logic [3:0] wr_dec, rd_dec;
	logic [7:0] tb_s1_ff, tb_s2_ff, tb_s3_ff, tb_in_ff;
	logic ser_s1_ff, ser_s2_ff, ser_s3_ff, ser_ff;
	logic lencnt_prev_ff;
	logic slow_tick_ff;
	logic [7:0] tm1, tm2, tone;
	logic auto_default;

	// Address decode: bit 3 is hit, bits 2:0 the register number
	function automatic logic [3:0] reg_decode(input logic [11:0] adr);
		logic [3:0] res;
		res = 4'h0;
		for (int k = 0; k < btc_pkg::NREG; k++) begin
			if (adr == btc_pkg::REG_ADR[k]) begin
				res = {1'b1, 3'(k)};
			end
		end
		return res;
	endfunction

	// Threshold plus noise floor without overflow
	function automatic logic [8:0] add_floor(input logic [7:0] thr, input logic [7:0] flr);
		return {1'b0, thr} + {1'b0, flr};
	endfunction

	assign tm1 = regs_ff[btc_pkg::R_TM1];
	assign tm2 = regs_ff[btc_pkg::R_TM2];
	assign tone = regs_ff[btc_pkg::R_TONE];
	assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
	assign w_take = s_axi_wvalid_i & s_axi_wready_o;
	assign ar_take = s_axi_arvalid_i & s_axi_arready_o;
	assign commit = (wr_st_ff == btc_pkg::WR_IDLE) & aw_full_ff & w_full_ff;
	assign nxt_aw_full = commit ? 1'b0 : (aw_full_ff | aw_take);
	assign nxt_w_full = commit ? 1'b0 : (w_full_ff | w_take);
	assign nxt_rvalid = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);
	assign wr_dec = reg_decode(aw_addr_ff);
	assign rd_dec = reg_decode(s_axi_araddr_i);

	// Write address and data are accepted independently, in either order
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			aw_full_ff <= 1'b0;
			w_full_ff <= 1'b0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			aw_addr_ff <= 12'h000;
			w_data_ff <= 8'h00;
			w_lane0_ff <= 1'b0;
		end else begin
			aw_full_ff <= nxt_aw_full;
			w_full_ff <= nxt_w_full;
			s_axi_awready_o <= ~nxt_aw_full;
			s_axi_wready_o <= ~nxt_w_full;
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr_i;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata_i[7:0];
				w_lane0_ff <= s_axi_wstrb_i[0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_st_ff <= btc_pkg::WR_IDLE;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= btc_pkg::RESP_OKAY;
		end else begin
			case (wr_st_ff)
				btc_pkg::WR_IDLE: begin
					if (commit) begin
						s_axi_bvalid_o <= 1'b1;
						s_axi_bresp_o <= wr_dec[3] ? btc_pkg::RESP_OKAY : btc_pkg::RESP_SLVERR;
						wr_st_ff <= btc_pkg::WR_RESP;
					end
				end
				btc_pkg::WR_RESP: begin
					if (s_axi_bready_i) begin
						s_axi_bvalid_o <= 1'b0;
						wr_st_ff <= btc_pkg::WR_IDLE;
					end
				end
				default: begin
					s_axi_bvalid_o <= 1'b0;
					wr_st_ff <= btc_pkg::WR_IDLE;
				end
			endcase
		end
	end

	// All eight bits are stored, unused ones included
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int k = 0; k < btc_pkg::NREG; k++) begin
				regs_ff[k] <= btc_pkg::REG_RST;
			end
		end else if (commit && wr_dec[3] && w_lane0_ff) begin
			regs_ff[wr_dec[2:0]] <= w_data_ff; // RULE24 RULE17 RULE23
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= btc_pkg::RESP_OKAY;
		end else begin
			s_axi_arready_o <= ~nxt_rvalid;
			s_axi_rvalid_o <= nxt_rvalid;
			if (ar_take) begin
				s_axi_rdata_o <= rd_dec[3] ? {24'h00_0000, regs_ff[rd_dec[2:0]]} : 32'h0000_0000;
				s_axi_rresp_o <= rd_dec[3] ? btc_pkg::RESP_OKAY : btc_pkg::RESP_SLVERR;
			end
		end
	end

	// Pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tb_s1_ff <= 8'h00;
			tb_s2_ff <= 8'h00;
			tb_s3_ff <= 8'h00;
			tb_in_ff <= 8'h00;
			ser_s1_ff <= 1'b0;
			ser_s2_ff <= 1'b0;
			ser_s3_ff <= 1'b0;
			ser_ff <= 1'b0;
		end else begin
			tb_s1_ff <= test_bus_input_i;
			tb_s2_ff <= tb_s1_ff;
			tb_s3_ff <= tb_s2_ff;
			for (int k = 0; k < 8; k++) begin
				if (tb_s2_ff[k] == tb_s3_ff[k]) begin
					tb_in_ff[k] <= tb_s3_ff[k];
				end
			end
			ser_s1_ff <= serial_data_in_pin_i;
			ser_s2_ff <= ser_s1_ff;
			ser_s3_ff <= ser_s2_ff;
			if (ser_s2_ff == ser_s3_ff) begin
				ser_ff <= ser_s3_ff;
			end
		end
	end

	// Noise generators: index 0 on the fast receive rate, index 1 at half that rate
	btc_noise_if noise_if [2] ();
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			slow_tick_ff <= 1'b0;
		end else begin
			slow_tick_ff <= ~slow_tick_ff;
		end
	end
	assign noise_if[0].enable = tm1[btc_pkg::TM1_NOISE_FAST]; // RULE7 RULE8
	assign noise_if[0].step = 1'b1;
	assign noise_if[1].enable = tm1[btc_pkg::TM1_NOISE_SLOW]; // RULE7 RULE8
	assign noise_if[1].step = slow_tick_ff;
	generate
		for (genvar g = 0; g < 2; g++) begin : g_noise
			btc_noise_gen u_noise (
				.clk_i(clk_i),
				.srst_i(srst_i),
				.ng(noise_if[g])
			);
		end
	endgenerate

	// Plain mode bits
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dac_test7_iq_o <= 1'b0;
			force_high_rate_o <= 1'b0;
			length_counts_bits_o <= 1'b0;
			spread_bypass_o <= 1'b0;
			scrambler_taps_zero_o <= 1'b0;
			coherent_gain_off_o <= 1'b0;
			dc_comp_en_o <= 1'b1;
			loopback_o <= 1'b0;
			test_bus_select_o <= 8'h00;
		end else begin
			dac_test7_iq_o <= tm1[btc_pkg::TM1_DAC7]; // RULE1
			force_high_rate_o <= tm1[btc_pkg::TM1_HIRATE]; // RULE2
			length_counts_bits_o <= tm1[btc_pkg::TM1_LENCNT]; // RULE3
			spread_bypass_o <= tm1[btc_pkg::TM1_NOSPREAD]; // RULE5
			scrambler_taps_zero_o <= tm1[btc_pkg::TM1_NOSCR]; // RULE6
			coherent_gain_off_o <= tm2[btc_pkg::TM2_NOCGC]; // RULE9
			dc_comp_en_o <= ~tm2[btc_pkg::TM2_NODC]; // RULE12
			loopback_o <= tm2[btc_pkg::TM2_LOOP]; // RULE15
			test_bus_select_o <= regs_ff[btc_pkg::R_TBS]; // RULE17
		end
	end

	// One-cycle receiver reset when bit counting is switched on
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lencnt_prev_ff <= 1'b0;
			rx_reset_o <= 1'b0;
		end else begin
			lencnt_prev_ff <= tm1[btc_pkg::TM1_LENCNT];
			rx_reset_o <= tm1[btc_pkg::TM1_LENCNT] & ~lencnt_prev_ff; // RULE3
		end
	end

	// Time tracking: disable wins over forced lock, else automatic detection
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			locked_time_track_o <= 1'b0;
			time_track_off_o <= 1'b0;
		end else begin
			time_track_off_o <= tm2[btc_pkg::TM2_NOTRACK]; // RULE14
			if (tm2[btc_pkg::TM2_NOTRACK]) begin
				locked_time_track_o <= 1'b0; // RULE14
			end else if (tm2[btc_pkg::TM2_FORCELOCK]) begin
				locked_time_track_o <= 1'b1; // RULE10
			end else begin
				locked_time_track_o <= rx_service_i[btc_pkg::SVC_LOCK_BIT]
					& config_reg_six_lock_i; // RULE11
			end
		end
	end

	// Receive sample source and acquisition lock; loopback ignores converters
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_i_o <= 6'h00;
			rx_q_o <= 6'h00;
			acq_lock_o <= 1'b0;
		end else begin
			if (tm2[btc_pkg::TM2_LOOP]) begin
				rx_i_o <= loop_i_i; // RULE15
				rx_q_o <= loop_q_i;
				acq_lock_o <= ser_ff; // RULE15
			end else if (tm2[btc_pkg::TM2_ADCBYP]) begin
				rx_i_o <= {tb_in_ff[3:0], 2'b00}; // RULE13
				rx_q_o <= {tb_in_ff[7:4], 2'b00}; // RULE13
				acq_lock_o <= acq_lock_i;
			end else begin
				rx_i_o <= adc_i_i;
				rx_q_o <= adc_q_i;
				acq_lock_o <= acq_lock_i;
			end
		end
	end

	// Test bus drive with optional noise overlay
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			test_bus_o <= 8'h00;
			test_bus_oe_o <= 1'b0;
		end else begin
			test_bus_oe_o <= ~tm1[btc_pkg::TM1_TBIN]; // RULE4
			test_bus_o[2:0] <= tm2[btc_pkg::TM2_NOISE_LO] ? noise_if[0].word[2:0]
				: test_probe_i[2:0]; // RULE16
			test_bus_o[7:3] <= tm2[btc_pkg::TM2_NOISE_HI] ? noise_if[1].word[4:0]
				: test_probe_i[7:3]; // RULE16
		end
	end

	// Matched filter weight choice
	always_comb begin
		auto_default = (continuous_wave_tone_i && ({1'b0, rssi_i}
			< add_floor({3'b000, tone[4:0]}, noise_floor_i)))
			|| (!continuous_wave_tone_i && ({1'b0, rssi_i}
			< add_floor({4'h0, regs_ff[btc_pkg::R_SNR1][3:0]}, noise_floor_i)))
			|| (!continuous_wave_tone_i
			&& (delay_spread_i < regs_ff[btc_pkg::R_DS][4:0])
			&& ({1'b0, rssi_i}
			< add_floor({3'b000, regs_ff[btc_pkg::R_SNR2][4:0]}, noise_floor_i))); // RULE20 RULE23
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			use_default_weights_o <= 1'b0;
			energy_detect_o <= 1'b0;
		end else begin
			// Both force bits set is undefined; default then wins
			use_default_weights_o <= tone[btc_pkg::TONE_FDEF]
				| (~tone[btc_pkg::TONE_FCALC] & auto_default); // RULE21 RULE22
			if (regs_ff[btc_pkg::R_ENERGY][btc_pkg::ENERGY_ABS]) begin
				energy_detect_o <= rssi_i[6:0] > regs_ff[btc_pkg::R_ENERGY][6:0]; // RULE18 RULE19
			end else begin
				energy_detect_o <= {1'b0, rssi_i} > add_floor({1'b0,
					regs_ff[btc_pkg::R_ENERGY][6:0]}, noise_floor_i); // RULE18 RULE19
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	property p_len_reset;
		$rose(tm1[btc_pkg::TM1_LENCNT]) |=> rx_reset_o ##1 !rx_reset_o;
	endproperty
	a_len_reset: assert property (p_len_reset) else $error("no receiver reset pulse"); // RULE3
	property p_tb_hiz;
		tm1[btc_pkg::TM1_TBIN] |=> !test_bus_oe_o;
	endproperty
	a_tb_hiz: assert property (p_tb_hiz) else $error("test bus still driven"); // RULE4
	property p_scr;
		tm1[btc_pkg::TM1_NOSCR] |=> scrambler_taps_zero_o;
	endproperty
	a_scr: assert property (p_scr) else $error("scrambler taps not zeroed"); // RULE6
	property p_noise_init;
		!tm1[btc_pkg::TM1_NOISE_FAST] |=> noise_if[0].word == btc_pkg::NOISE_SEED;
	endproperty
	a_noise_init: assert property (p_noise_init) else $error("generator not initialised"); // RULE7
	property p_noise_init_slow;
		!tm1[btc_pkg::TM1_NOISE_SLOW] |=> noise_if[1].word == btc_pkg::NOISE_SEED;
	endproperty
	a_noise_init_slow: assert property (p_noise_init_slow) else $error("slow generator not initialised"); // RULE7
	property p_no_track;
		tm2[btc_pkg::TM2_NOTRACK] |=> !locked_time_track_o && time_track_off_o;
	endproperty
	a_no_track: assert property (p_no_track) else $error("tracking not disabled"); // RULE14
	property p_force_lock;
		tm2[btc_pkg::TM2_FORCELOCK] && !tm2[btc_pkg::TM2_NOTRACK] |=> locked_time_track_o;
	endproperty
	a_force_lock: assert property (p_force_lock) else $error("lock not forced"); // RULE10
	property p_auto_lock;
		!tm2[btc_pkg::TM2_FORCELOCK] && !config_reg_six_lock_i |=> !locked_time_track_o;
	endproperty
	a_auto_lock: assert property (p_auto_lock) else $error("auto lock without enable"); // RULE11
	property p_bypass;
		tm2[btc_pkg::TM2_ADCBYP] && !tm2[btc_pkg::TM2_LOOP]
			|=> rx_i_o == {$past(tb_in_ff[3:0]), 2'b00}
			&& rx_q_o == {$past(tb_in_ff[7:4]), 2'b00};
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass sample mismatch"); // RULE13
	property p_loop;
		tm2[btc_pkg::TM2_LOOP] |=> acq_lock_o == $past(ser_ff) && rx_i_o == $past(loop_i_i)
			&& rx_q_o == $past(loop_q_i);
	endproperty
	a_loop: assert property (p_loop) else $error("lock not from serial pin"); // RULE15
	property p_force_def;
		tone[btc_pkg::TONE_FDEF] |=> use_default_weights_o;
	endproperty
	a_force_def: assert property (p_force_def) else $error("default weights not forced"); // RULE21
	property p_bresp;
		commit |=> s_axi_bvalid_o;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response missing");

	c_write: cover property (commit && wr_dec[3]);
	c_read_bad: cover property (ar_take && !rd_dec[3]);
	c_loop: cover property (tm2[btc_pkg::TM2_LOOP] && ser_ff);
	c_calc: cover property (!use_default_weights_o ##1 use_default_weights_o);
endmodule

/* File: verification/baseband_test_and_cmf_config_tb.sv */
// Self-checking bench for the test mode and weight selection registers
`timescale 1ns/100ps
module baseband_test_and_cmf_config_tb;
	logic clk_i = 1'b0;
	logic srst_i;
	logic [11:0] awaddr = '0;
	logic [11:0] araddr = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] tbin = '0, probe = '0, svc = '0, rssi = '0, nf = '0;
	logic ser = 1'b0, lock = 1'b0, cfg6 = 1'b0, tone = 1'b0;
	logic [5:0] ai = '0, aq = '0, li = '0, lq = '0;
	logic [4:0] ds = '0;
	logic [7:0] tb_o, tbs_o;
	logic oe, d7, fhr, lcb, rxr, spb, scz, cgo, dce, ltt, tto, lpb, acq, edo, udw;
	logic [5:0] ri, rq;
	logic [7:0] mreg [8];
	logic [31:0] seed = 32'h9abf;
	int error_cnt = 0;
	int n_tests = 0;
	int pulses = 0;
	// Noise enables and unused bits, except bits 7:5 of the delay spread register, stay zero in random writes
	localparam logic [7:0] MASK [8] = '{8'hfc, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h0f, 8'h1f};
	// Test bus image of both generators held at their seed
	localparam logic [7:0] SEED_BUS = {btc_pkg::NOISE_SEED[4:0], btc_pkg::NOISE_SEED[2:0]};

	btc_top uut (
		.clk_i(clk_i), .srst_i(srst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.test_bus_input_i(tbin), .test_bus_o(tb_o), .test_bus_oe_o(oe), .test_probe_i(probe),
		.serial_data_in_pin_i(ser), .acq_lock_i(lock), .adc_i_i(ai), .adc_q_i(aq),
		.loop_i_i(li), .loop_q_i(lq), .rx_service_i(svc), .config_reg_six_lock_i(cfg6),
		.rssi_i(rssi), .noise_floor_i(nf), .continuous_wave_tone_i(tone), .delay_spread_i(ds),
		.dac_test7_iq_o(d7), .force_high_rate_o(fhr), .length_counts_bits_o(lcb),
		.rx_reset_o(rxr), .spread_bypass_o(spb), .scrambler_taps_zero_o(scz),
		.coherent_gain_off_o(cgo), .dc_comp_en_o(dce), .locked_time_track_o(ltt),
		.time_track_off_o(tto), .loopback_o(lpb), .rx_i_o(ri), .rx_q_o(rq), .acq_lock_o(acq),
		.test_bus_select_o(tbs_o), .energy_detect_o(edo), .use_default_weights_o(udw)
	);

	always #10 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (rxr === 1'b1)
			pulses <= pulses + 1;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		for (int k = 0; k < 8; k++)
			s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction

	function automatic int idx(input logic [11:0] a);
		for (int i = 0; i < 8; i++)
			if (a == btc_pkg::REG_ADR[i])
				return i;
		return -1;
	endfunction

	task automatic summarize();
		$display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st);
		int n;
		int k;
		n = 0;
		k = idx(a);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0000, d};
		wstrb <= st;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid && bready) && n < 50);
		if (n >= 50) begin
			error_cnt++;
			summarize();
		end
		chk(32'(bresp), 32'(k >= 0 ? btc_pkg::RESP_OKAY : btc_pkg::RESP_SLVERR));
		if (k >= 0 && st[0])
			mreg[k] = d;
		bready <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic axi_rd(input logic [11:0] a);
		int n;
		int k;
		n = 0;
		k = idx(a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!(rvalid && rready) && n < 50);
		if (n >= 50) begin
			error_cnt++;
			summarize();
		end
		chk(rdata, k >= 0 ? {24'h0000, mreg[k]} : 32'h0000_0000);
		chk(32'(rresp), 32'(k >= 0 ? btc_pkg::RESP_OKAY : btc_pkg::RESP_SLVERR));
		rready <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic do_reset();
		srst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 8; i++)
			mreg[i] = btc_pkg::REG_RST;
		@(posedge clk_i);
		chk(32'({d7, fhr, lcb, rxr, spb, scz, cgo, ltt, tto, lpb, edo, udw, oe, acq}), 32'h0);
		chk(32'({tb_o, tbs_o, ri, rq, bvalid, rvalid, dce}), 32'h1);
	endtask

	task automatic rnd_inputs();
		seed = lfsr_next(seed);
		{tbin, probe, svc, rssi} <= seed;
		seed = lfsr_next(seed);
		{nf, ai, aq, li, lq} <= seed;
		seed = lfsr_next(seed);
		{ser, lock, cfg6, tone, ds} <= seed[8:0];
	endtask

	task automatic check_outs();
		logic [7:0] t1, t2, e, tn, xtb;
		logic [12:0] xr;
		logic dflt, xed;
		int r, f;
		t1 = mreg[btc_pkg::R_TM1];
		t2 = mreg[btc_pkg::R_TM2];
		e = mreg[btc_pkg::R_ENERGY];
		tn = mreg[btc_pkg::R_TONE];
		r = rssi;
		f = nf;
		chk(32'({d7, fhr, lcb}), 32'(t1[7:5]));
		chk(32'({oe, spb, scz}), 32'({~t1[4], t1[3:2]}));
		chk(32'({cgo, dce, lpb}), 32'({t2[7], ~t2[5], t2[2]}));
		chk(32'({tto, ltt}), 32'({t2[3], !t2[3] && (t2[6] || (svc[2] && cfg6))}));
		xr = t2[2] ? {li, lq, ser} : t2[4] ? {tbin[3:0], 2'b00, tbin[7:4], 2'b00, lock} : {ai, aq, lock};
		chk(32'({ri, rq, acq}), 32'(xr));
		chk(32'(tbs_o), 32'(mreg[btc_pkg::R_TBS]));
		xtb = {t2[0] ? SEED_BUS[7:3] : probe[7:3], t2[1] ? SEED_BUS[2:0] : probe[2:0]};
		chk(32'(tb_o), 32'(xtb));
		xed = e[7] ? (rssi[6:0] > e[6:0]) : (r > e[6:0] + f);
		chk(32'(edo), 32'(xed));
		dflt = (tone && r < tn[4:0] + f) || (!tone && r < mreg[btc_pkg::R_SNR1][3:0] + f)
			|| (!tone && ds < mreg[btc_pkg::R_DS][4:0] && r < mreg[btc_pkg::R_SNR2][4:0] + f);
		chk(32'(udw), 32'(tn[6] | (~tn[5] & dflt)));
	endtask

	initial begin
		logic [7:0] v;
		logic ch;
		int n;
		do_reset();
		for (int i = 0; i < 8; i++)
			axi_rd(btc_pkg::REG_ADR[i]);
		for (int r = 0; r < 16; r++) begin
			rnd_inputs();
			for (int i = 0; i < 8; i++) begin
				seed = lfsr_next(seed);
				v = seed[7:0] & MASK[i];
				if (i == btc_pkg::R_TONE && v[6])
					v[5] = 1'b0;
				axi_wr(btc_pkg::REG_ADR[i], v, 4'h1);
			end
			for (int i = 0; i < 8; i++)
				axi_rd(btc_pkg::REG_ADR[i]);
			repeat (6) @(posedge clk_i);
			check_outs();
		end
		// Unmapped places and a write with the low strobe off
		for (int i = 0; i < 8; i++) begin
			axi_wr(12'h104 + 12'(i * 8), 8'h5a, 4'h1);
			axi_rd(12'h104 + 12'(i * 8));
		end
		axi_wr(12'h000, 8'h5a, 4'h1);
		axi_rd(12'h000);
		axi_wr(btc_pkg::REG_ADR[btc_pkg::R_TBS], 8'ha5, 4'h0);
		axi_rd(btc_pkg::REG_ADR[btc_pkg::R_TBS]);
		// Receiver reset pulse on enabling the length counter
		axi_wr(btc_pkg::REG_ADR[btc_pkg::R_TM1], 8'h00, 4'h1);
		repeat (4) @(posedge clk_i);
		n = pulses;
		axi_wr(btc_pkg::REG_ADR[btc_pkg::R_TM1], 8'h20, 4'h1);
		repeat (6) @(posedge clk_i);
		chk(32'(pulses - n), 32'd1);
		// Noise generators held at seed, then running, then re-seeded
		axi_wr(btc_pkg::REG_ADR[btc_pkg::R_TM1], 8'h00, 4'h1);
		axi_wr(btc_pkg::REG_ADR[btc_pkg::R_TM2], 8'h03, 4'h1);
		repeat (6) @(posedge clk_i);
		chk(32'(tb_o), 32'(SEED_BUS));
		axi_wr(btc_pkg::REG_ADR[btc_pkg::R_TM1], 8'h03, 4'h1);
		ch = 1'b0;
		repeat (10) begin
			@(posedge clk_i);
			if (tb_o !== SEED_BUS)
				ch = 1'b1;
		end
		chk(32'(ch), 32'd1);
		axi_wr(btc_pkg::REG_ADR[btc_pkg::R_TM1], 8'h00, 4'h1);
		repeat (6) @(posedge clk_i);
		chk(32'(tb_o), 32'(SEED_BUS));
		// Reset again in mid-run, registers return to zero
		do_reset();
		for (int i = 0; i < 8; i++)
			axi_rd(btc_pkg::REG_ADR[i]);
		summarize();
	end
endmodule
